// *** src/ccsp_cfg.svh ***
// Constants for the current channel sample path.
`ifndef CCSP_CFG_SVH
`define CCSP_CFG_SVH
`define CCSP_MOD_DIV 16
`define CCSP_DEC_RATIO 128
`define CCSP_CODE_MAX 24'h7FFFFF
`define CCSP_CODE_MIN 24'h800000
`define CCSP_FS_CODE 24'h514791
`define CCSP_GAIN_FRAC 23
`define CCSP_HPF_SHIFT 8
`define CCSP_FLAG_READY_BIT 17
`define CCSP_MASK_READY_BIT 17
`define CCSP_HPF_EN_BIT 0
`define CCSP_SETUP_RESET 8'h01
`define CCSP_WORD_PAD 4'h0
`define CCSP_PWR_FULL 7'h7F
`define CCSP_PWR_CURR 7'h07
`define CCSP_PWR_OFF 7'h00
`define CCSP_SIGN_BITS 8
`endif

// *** src/ccsp_pkg.sv ***
// Types shared by the current channel sample path.
package ccsp_pkg;
  typedef enum logic [3:0] {
    CCSP_FULL = 4'h1,
    CCSP_CURR = 4'h2,
    CCSP_LOW2 = 4'h4,
    CCSP_SLEEP = 4'h8
  } ccsp_mode_t;
  typedef struct packed {
    logic [23:0] phase_a;
    logic [23:0] phase_b;
    logic [23:0] phase_c;
    logic [23:0] neutral;
  } ccsp_samples_t;
endpackage : ccsp_pkg

// *** src/ccsp_top.sv ***
// Current channel converter control, gain, DC removal and sample capture.
// How it works
// - Full power mode runs all seven converters.
// - Current-only mode runs three phase current converters.
// - Low power modes power down every converter.
// - Modulator clock is master clock over sixteen.
// - Decimator averages bitstream into 24-bit signed words.
// - Codes are two's complement, saturated to limits.
// - Same scaling on all channels, full scale 0x514791.
// - Current words delivered at 8 kSPS.
// - Neutral path mirrors phase current paths.
// - Gain multiplies by one plus gain over 2^23.
// - Gained value feeds samples and metering output.
// - Gain words are 28-bit sign extended, top zero.
// - Setup bit 0 enables all DC-removal filters.
// - Samples taken after high-pass filter at 8 kSPS.
// - Ready flag bit 17 set on new samples.
// - Mask bit 17 gates ready onto interrupt.
// - Sample reads return 32-bit sign-extended words.
`timescale 1ns/1ps
`default_nettype none
`include "ccsp_cfg.svh"
module ccsp_top
  import ccsp_pkg::*;
#(
  parameter int DEC_RATIO = `CCSP_DEC_RATIO,
  parameter int MOD_DIV = `CCSP_MOD_DIV
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire ccsp_mode_t power_mode,
  input wire logic [6:0] mod_bits,
  input wire logic [31:0] phase_a_current_gain,
  input wire logic [31:0] phase_b_current_gain,
  input wire logic [31:0] phase_c_current_gain,
  input wire logic [31:0] neutral_current_gain,
  input wire logic [7:0] third_setup_register,
  input wire logic [31:0] first_event_mask,
  input wire logic [31:0] flag_clear,
  input wire logic flag_clear_wr,
  input wire logic [1:0] read_sel,
  output logic [6:0] conv_power_en,
  output logic mod_clk,
  output logic [31:0] first_event_flags,
  output logic irq_n,
  output logic [31:0] read_word,
  output var ccsp_samples_t dsp_samples,
  output logic dsp_valid
);
  localparam int CW = $clog2(DEC_RATIO) + 2;
  localparam int DW = $clog2(MOD_DIV);

  // Refuse sizes the counters cannot serve: both counters wrap on an all-ones count,
  // so only powers of two give the intended periods.
  if (DEC_RATIO < 2 || (DEC_RATIO & (DEC_RATIO - 1)) != 0) begin : g_bad_dec
    $error("DEC_RATIO must be a power of two of at least 2.");
  end
  if (MOD_DIV < 2 || (MOD_DIV & (MOD_DIV - 1)) != 0) begin : g_bad_div
    $error("MOD_DIV must be a power of two of at least 2.");
  end

  // Saturate a wide signed value into the 24-bit code range.
  // Clipping, not wrapping, keeps an overdriven input from flipping sign.
  function automatic logic [23:0] sat24(input logic signed [55:0] v);
    if (v > $signed({{32{1'b0}}, `CCSP_CODE_MAX})) return `CCSP_CODE_MAX;
    else if (v < $signed({{32{1'b1}}, `CCSP_CODE_MIN})) return `CCSP_CODE_MIN;
    else return v[23:0];
  endfunction : sat24

  // Apply code * (1 + gain / 2^23); gain comes in a 28-bit container.
  function automatic logic [23:0] apply_gain(input logic [23:0] code, input logic [31:0] g);
    logic signed [55:0] prod;
    prod = $signed({{32{code[23]}}, code}) * $signed({{28{g[27]}}, g[27:0]});
    return sat24($signed({{32{code[23]}}, code}) + (prod >>> `CCSP_GAIN_FRAC));
  endfunction : apply_gain

  // Converter power gating by mode: bits 0..2 phase currents, 3 neutral, 4..6 voltages.
  // Enables are registered, so a mode change takes effect one clock later.
  logic [6:0] pwr_nxt;
  always_comb begin
    unique case (power_mode)
      CCSP_FULL: pwr_nxt = `CCSP_PWR_FULL;
      CCSP_CURR: pwr_nxt = `CCSP_PWR_CURR;
      CCSP_LOW2: pwr_nxt = `CCSP_PWR_OFF;
      CCSP_SLEEP: pwr_nxt = `CCSP_PWR_OFF;
      default: pwr_nxt = `CCSP_PWR_OFF;
    endcase
  end

  // Sample clock divider; the decimator advances on one tick per modulator period.
  // The square wave lags the count by one clock; only its period matters outside.
  logic [DW-1:0] div_r, div_nxt;
  logic mod_clk_nxt, tick;
  always_comb begin
    div_nxt = div_r + DW'(1);
    mod_clk_nxt = div_r[DW-1];
    tick = (div_r == '1);
  end

  // Decimation: first-order averaging of bipolar bits over DEC_RATIO periods.
  // A plain box average trades stopband rejection for small area.
  // A converter that is powered down restarts from zero, so its first word is short.
  logic signed [CW-1:0] acc_r [4];
  logic signed [CW-1:0] acc_nxt [4];
  logic [CW-3:0] dcnt_r, dcnt_nxt;
  logic dec_done;
  logic [23:0] raw [4];
  always_comb begin
    dcnt_nxt = dcnt_r;
    dec_done = 1'b0;
    for (int i = 0; i < 4; i++) begin
      acc_nxt[i] = acc_r[i];
      raw[i] = sat24($signed(56'(acc_r[i])) * $signed(56'(`CCSP_FS_CODE))
                     / $signed(56'(DEC_RATIO)));
    end
    if (tick) begin
      dcnt_nxt = dcnt_r + (CW-2)'(1);
      dec_done = (dcnt_r == '1);
      for (int i = 0; i < 4; i++) begin
        if (!conv_power_en[i]) acc_nxt[i] = '0;
        else if (dec_done) acc_nxt[i] = mod_bits[i] ? CW'(1) : -CW'(1);
        else acc_nxt[i] = acc_r[i] + (mod_bits[i] ? CW'(1) : -CW'(1));
      end
    end
  end

  // Gain then DC removal (first-order leaky high-pass) per current channel.
  // The filter state moves only on a sample set, so its corner tracks the sample rate.
  logic signed [31:0] dc_r [4];
  logic signed [31:0] dc_nxt [4];
  ccsp_samples_t smp_r, smp_nxt;
  logic [23:0] gained [4];
  logic [23:0] hp [4];
  logic hpf_en, new_set;
  always_comb begin
    hpf_en = third_setup_register[`CCSP_HPF_EN_BIT];
    new_set = dec_done && (conv_power_en[2:0] != 3'h0);
    smp_nxt = smp_r;
    gained[0] = apply_gain(raw[0], phase_a_current_gain);
    gained[1] = apply_gain(raw[1], phase_b_current_gain);
    gained[2] = apply_gain(raw[2], phase_c_current_gain);
    gained[3] = apply_gain(raw[3], neutral_current_gain);
    for (int i = 0; i < 4; i++) begin
      dc_nxt[i] = dc_r[i];
      hp[i] = hpf_en ? sat24(56'($signed(gained[i])) - 56'(dc_r[i] >>> `CCSP_HPF_SHIFT))
                     : gained[i];
      if (new_set) begin
        dc_nxt[i] = hpf_en ? dc_r[i] + 32'($signed(hp[i])) : 32'h0;
      end
    end
    if (new_set) begin
      smp_nxt = '{phase_a: hp[0], phase_b: hp[1], phase_c: hp[2], neutral: hp[3]};
    end
  end

  // Ready flag: set wins over a clear in the same cycle; interrupt is masked flag.
  logic flag_r, flag_nxt, irq_n_nxt, valid_nxt;
  logic [31:0] rd_nxt;
  logic [31:0] flags_nxt;
  always_comb begin
    flag_nxt = flag_r;
    if (flag_clear_wr && flag_clear[`CCSP_FLAG_READY_BIT]) flag_nxt = 1'b0;
    if (new_set) flag_nxt = 1'b1;
    // The flag word is registered whole so the output leaves a flip-flop.
    flags_nxt = 32'h0;
    flags_nxt[`CCSP_FLAG_READY_BIT] = flag_nxt;
    irq_n_nxt = !(flag_nxt && first_event_mask[`CCSP_MASK_READY_BIT]);
    valid_nxt = new_set;
    unique case (read_sel)
      2'h0: rd_nxt = {{`CCSP_SIGN_BITS{smp_r.phase_a[23]}}, smp_r.phase_a};
      2'h1: rd_nxt = {{`CCSP_SIGN_BITS{smp_r.phase_b[23]}}, smp_r.phase_b};
      2'h2: rd_nxt = {{`CCSP_SIGN_BITS{smp_r.phase_c[23]}}, smp_r.phase_c};
      2'h3: rd_nxt = {{`CCSP_SIGN_BITS{smp_r.neutral[23]}}, smp_r.neutral};
    endcase
  end

  // Register everything.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= '0;
      mod_clk <= 1'b0;
      dcnt_r <= '0;
      conv_power_en <= 7'h00;
      smp_r <= '0;
      flag_r <= 1'b0;
      irq_n <= 1'b1;
      first_event_flags <= 32'h0;
      read_word <= 32'h0;
      dsp_valid <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= '0;
        dc_r[i] <= 32'h0;
      end
    end else begin
      div_r <= div_nxt;
      mod_clk <= mod_clk_nxt;
      dcnt_r <= dcnt_nxt;
      conv_power_en <= pwr_nxt;
      smp_r <= smp_nxt;
      flag_r <= flag_nxt;
      irq_n <= irq_n_nxt;
      first_event_flags <= flags_nxt;
      read_word <= rd_nxt;
      dsp_valid <= valid_nxt;
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= acc_nxt[i];
        dc_r[i] <= dc_nxt[i];
      end
    end
  end

  assign dsp_samples = smp_r;

  // Checks.
  sequence s_set;
    new_set;
  endsequence
  AST_FULL_PWR: assert property (@(posedge clk) disable iff (!arst_n)
    power_mode == CCSP_FULL |=> conv_power_en == 7'h7F) else $error("full mode power");
  AST_CURR_PWR: assert property (@(posedge clk) disable iff (!arst_n)
    power_mode == CCSP_CURR |=> conv_power_en == 7'h07) else $error("curr mode power");
  AST_LOW_PWR: assert property (@(posedge clk) disable iff (!arst_n)
    (power_mode == CCSP_LOW2 || power_mode == CCSP_SLEEP) |=> conv_power_en == 7'h00)
    else $error("low mode power");
  AST_DIV: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(mod_clk) |-> ##8 $fell(mod_clk)) else $error("mod clk period");
  AST_READY_SET: assert property (@(posedge clk) disable iff (!arst_n)
    s_set |=> flag_r && dsp_valid) else $error("ready not set");
  AST_SAMPLE_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    !new_set |=> $stable(smp_r)) else $error("samples changed off tick");
  AST_IRQ: assert property (@(posedge clk) disable iff (!arst_n)
    flag_r && first_event_mask[`CCSP_MASK_READY_BIT] && $stable(first_event_mask) &&
    !flag_clear_wr |=> !irq_n)
    else $error("irq missing");
  AST_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    flag_clear_wr && flag_clear[`CCSP_FLAG_READY_BIT] && !new_set |=> !flag_r ##1 irq_n)
    else $error("clear failed");
  AST_SIGNEXT: assert property (@(posedge clk) disable iff (!arst_n)
    read_word[31:24] == {8{read_word[23]}}) else $error("sign extension");

  // A set and a clear in the same cycle: the set must win, or a host that clears
  // late would lose a whole sample set without ever seeing its flag.
  sequence s_clear;
    flag_clear_wr && flag_clear[`CCSP_FLAG_READY_BIT];
  endsequence
  AST_SET_WINS: assert property (@(posedge clk) disable iff (!arst_n)
    s_set and s_clear |=> flag_r) else $error("clear beat a set");

  // Without a clear strobe the ready flag holds.
  AST_HOLD_FLAG: assert property (@(posedge clk) disable iff (!arst_n)
    flag_r && !flag_clear_wr |=> flag_r) else $error("flag dropped");

  // The mask gates the request; with the mask bit low the line stays high.
  AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (!arst_n)
    !first_event_mask[`CCSP_MASK_READY_BIT] |=> irq_n) else $error("masked irq");

  // A fresh set with the mask open pulls the request low on the next edge.
  sequence s_set_open;
    new_set && first_event_mask[`CCSP_MASK_READY_BIT];
  endsequence
  AST_IRQ_ON_SET: assert property (@(posedge clk) disable iff (!arst_n)
    s_set_open |=> !irq_n) else $error("irq late on set");

  // No sample set may appear while the phase current converters are dark.
  AST_NO_SET_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    conv_power_en[2:0] == 3'h0 |-> !new_set) else $error("set while off");

  // The neutral converter, when switched off, has its accumulator cleared at each tick.
  AST_NEUTRAL_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    !conv_power_en[3] && tick |=> acc_r[3] == '0) else $error("neutral ran while off");

  // The flag word shows the ready flag at its own bit.
  AST_FLAG_BIT: assert property (@(posedge clk) disable iff (!arst_n)
    first_event_flags[`CCSP_FLAG_READY_BIT] == flag_r) else $error("flag bit");

  // Sets come one per decimation period, so a valid pulse never repeats soon.
  // Eight idle cycles are below the 32-clock period of DEC_RATIO 2 at MOD_DIV 16; the smallest legal sizes give a period of 4 clocks.
  AST_SET_SPACING: assert property (@(posedge clk) disable iff (!arst_n)
    s_set |=> !new_set [*8]) else $error("sets too close");
  AST_VALID_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
    dsp_valid |=> !dsp_valid) else $error("valid stuck");

  // The decimation counter starts a fresh period right after each sample word.
  AST_DEC_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
    dec_done |=> dcnt_r == '0) else $error("decimation count");

  // With unity gain and the filter off, the stored word is the raw converter code.
  AST_UNITY_GAIN: assert property (@(posedge clk) disable iff (!arst_n)
    new_set && !hpf_en && phase_b_current_gain == 32'h0
    |=> dsp_samples.phase_b == $past(raw[1])) else $error("unity gain");

  // With the filter off the stored word is the gained code itself.
  AST_HPF_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    new_set && !hpf_en |=> dsp_samples.phase_a == $past(gained[0])) else $error("hpf off");

  // Each read returns the word held before the read edge.
  AST_READ_A: assert property (@(posedge clk) disable iff (!arst_n)
    read_sel == 2'h0 |=> read_word[23:0] == $past(smp_r.phase_a)) else $error("read a");
  AST_READ_B: assert property (@(posedge clk) disable iff (!arst_n)
    read_sel == 2'h1 |=> read_word[23:0] == $past(smp_r.phase_b)) else $error("read b");
  AST_READ_C: assert property (@(posedge clk) disable iff (!arst_n)
    read_sel == 2'h2 |=> read_word[23:0] == $past(smp_r.phase_c)) else $error("read c");
  AST_READ_N: assert property (@(posedge clk) disable iff (!arst_n)
    read_sel == 2'h3 |=> read_word[23:0] == $past(smp_r.neutral)) else $error("read n");
endmodule : ccsp_top
`default_nettype wire

// *** tb/ccsp_host.sv ***
// Host model that drains the four current samples and clears the ready flag.
`timescale 1ns/1ps
`default_nettype none
module ccsp_host (
  input wire logic clk,
  input wire logic irq_n,
  input wire logic en,
  input wire logic [31:0] read_word,
  output logic [1:0] read_sel,
  output logic [31:0] flag_clear,
  output logic flag_clear_wr,
  output logic [127:0] got
);
  initial begin
    read_sel = 2'h0;
    flag_clear = 32'h0;
    flag_clear_wr = 1'b0;
    got = '0;
  end
  // The clear goes last so that no read can see a half updated set.
  always @(negedge clk) begin
    if (en && !irq_n) begin
      for (int i = 0; i < 4; i++) begin
        read_sel <= 2'(i);
        @(negedge clk);
        @(negedge clk);
        got[32*i +: 32] = read_word;
      end
      flag_clear <= 32'h00020000;
      flag_clear_wr <= 1'b1;
      @(negedge clk);
      flag_clear_wr <= 1'b0;
      flag_clear <= 32'hFFFFFFFF; // Stray bits must do nothing without the strobe.
      // The request line rises on the edge that takes the clear; still wait two cycles before looking again.
      @(negedge clk);
      @(negedge clk);
    end
  end
endmodule : ccsp_host
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the current channel sample path.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ccsp_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  ccsp_mode_t power_mode = CCSP_FULL;
  logic [6:0] mod_bits = 7'h7F;
  logic [31:0] gain_a = 32'h0;
  logic [7:0] setup = 8'h00;
  logic [31:0] mask = 32'h0;
  logic en = 1'b0;
  logic [1:0] read_sel;
  logic [31:0] flag_clear, first_event_flags, read_word;
  logic flag_clear_wr, mod_clk, irq_n, dsp_valid;
  logic [6:0] conv_power_en;
  logic [127:0] got;
  ccsp_samples_t dsp_samples;
  int miscompares = 0;
  int checks = 0;
  int rises;
  logic prev_mod;
  typedef struct {ccsp_mode_t m; logic [6:0] e;} row_t;
  row_t rows[4] = '{'{CCSP_FULL, 7'h7F}, '{CCSP_CURR, 7'h07}, '{CCSP_LOW2, 7'h00},
                    '{CCSP_SLEEP, 7'h00}};
  always #5 clk = ~clk;
  ccsp_top #(.DEC_RATIO(4), .MOD_DIV(16)) u_dut (.clk(clk), .arst_n(arst_n),
    .power_mode(power_mode), .mod_bits(mod_bits), .phase_a_current_gain(gain_a),
    .phase_b_current_gain(32'h0), .phase_c_current_gain(32'h0),
    .neutral_current_gain(32'h0), .third_setup_register(setup), .first_event_mask(mask),
    .flag_clear(flag_clear), .flag_clear_wr(flag_clear_wr), .read_sel(read_sel),
    .conv_power_en(conv_power_en), .mod_clk(mod_clk), .first_event_flags(first_event_flags),
    .irq_n(irq_n), .read_word(read_word), .dsp_samples(dsp_samples), .dsp_valid(dsp_valid));
  ccsp_host u_host (.clk(clk), .irq_n(irq_n), .en(en), .read_word(read_word),
    .read_sel(read_sel), .flag_clear(flag_clear), .flag_clear_wr(flag_clear_wr), .got(got));
  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Wait a number of sample sets, giving each one a bounded number of cycles.
  task automatic sets(input int n);
    int k;
    for (int s = 0; s < n; s++) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (dsp_valid !== 1'b1 && k < 200);
      if (k >= 200) chk("dsp_valid", 1'b0, 1'b1);
    end
    @(negedge clk);
  endtask : sets
  task automatic end_sim();
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    #100us;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (12) @(negedge clk);
    chk("irq_rst", irq_n, 1'b1);
    chk("flags_rst", first_event_flags, 32'h0);
    arst_n = 1'b1;
    // Table pass over every power mode.
    foreach (rows[i]) begin
      power_mode = rows[i].m;
      repeat (3) @(negedge clk);
      chk("power_en", conv_power_en, rows[i].e);
    end
    power_mode = CCSP_FULL;
    rises = 0;
    prev_mod = mod_clk;
    repeat (320) begin
      @(posedge clk);
      #1;
      if (mod_clk && !prev_mod) rises++;
      prev_mod = mod_clk;
    end
    chk("mod_rises", rises, 20);
    sets(4);
    chk("flag", first_event_flags, 32'h00020000);
    chk("irq_masked", irq_n, 1'b1);
    mask = 32'h00020000;
    en = 1'b1;
    sets(3);
    chk("samples", got, {4{32'h00514791}});
    chk("dsp_a", dsp_samples.phase_a, 24'h514791);
    // Filter on: the first set passes whole, the second loses a 1/256 step.
    setup = 8'h01;
    sets(1);
    chk("hpf_first", dsp_samples.phase_a, 24'h514791);
    sets(1);
    chk("hpf_decay", dsp_samples.phase_a, 24'h50F64A);
    setup = 8'h00;
    gain_a = 32'h0F800000;
    sets(4);
    chk("gain_min", got, {{3{32'h00514791}}, 32'h0});
    mod_bits = 7'h00;
    gain_a = 32'h0;
    sets(4);
    chk("negative", got, {4{32'hFFAEB86F}});
    power_mode = CCSP_SLEEP;
    repeat (300) @(negedge clk);
    chk("sleep_flag", first_event_flags, 32'h0);
    chk("sleep_irq", irq_n, 1'b1);
    end_sim();
  end
endmodule : tb
`default_nettype wire
